// [psv_consts.svh]
`ifndef WIN_CONSTS_SVH
`define WIN_CONSTS_SVH
`define WIN_PAGE_W 10
`define WIN_EN_BIT 9
`define WIN_UPPER_BIT 8
`define WIN_PAGE_LO_W 8
`define WIN_ADDR_W 16
`define WIN_ADDR_MSB 15
`define WIN_PADDR_W 23
`define WIN_DATA_W 16
`define WIN_PAGE_ZERO 10'h000
`define WIN_BASE 16'h8000
`define WIN_EXTRA_MOV 2'h1
`define WIN_EXTRA_OTHER 2'h2
`endif

// [psv_pkg.sv]
package window_pkg;
	typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_DWORD} size_e;
	typedef struct packed {
		logic [15:0] effective_addr;
		logic [9:0] readPage;
		logic [9:0] writePage;
		logic isRead;
		logic isWrite;
		size_e size;
		logic isMov;
		logic inRepeat;
		logic repFirst;
		logic repLast;
		logic repIntExit;
		logic repIntEntry;
	} req_s;
	typedef struct packed {
		logic [15:0] data;
		logic [15:0] dataHi;
		logic trap;
		logic [1:0] extraCycles;
		logic redirected;
	} rsp_s;
endpackage : window_pkg

// [psv_addr_map.sv]
`timescale 1ns/1ps
`include "psv_consts.svh"
module window_addr_map (
	// request
	input wire logic [15:0] effective_addr,
	input wire logic [9:0] data_read_page_register,
	// result
	output logic redirect,
	output logic upperHalf,
	output logic [22:0] progAddr
);
	always_comb begin
		redirect = effective_addr[`WIN_ADDR_MSB] & data_read_page_register[`WIN_EN_BIT]; // RL2 RL13
		upperHalf = data_read_page_register[`WIN_UPPER_BIT]; // RL4 RL6
		progAddr = {data_read_page_register[`WIN_PAGE_LO_W-1:0], effective_addr[14:0]}; // RL3 RL5 RL7
	end
endmodule : window_addr_map

// [program_space_data_window.sv]
`timescale 1ns/1ps
`include "psv_consts.svh"
// What this block does
// RL1 - The upper 32 Kbytes of data space map onto any selectable 16K-word page of program memory.
// RL2 - A read goes to program memory only when address bit 15 and page bit 9 are both set.
// RL3 - The 23-bit program address is the low eight page bits above pointer bits 14 to 0.
// RL4 - Page bit 8 selects the lower word when zero and the upper word when one.
// RL5 - There are 512 window pages, 200h to 3FFh, each of 16K words.
// RL6 - Pages to 2FFh give lower words and pages from 300h give upper words.
// RL7 - Page 200h maps 8000h-FFFFh to 000000h-007FFEh and page 2FFh to 7F8000h-7FFFFEh.
// RL8 - Upper-word reads give 4 Mbytes of real bytes, the rest phantom, and the window is read-only.
// RL9 - An access at or above 8000h with its page register at zero raises an address error trap.
// RL10 - Outside a repeat loop a window access adds one cycle for moves and two for other instructions.
// RL11 - Inside a repeat loop it adds two cycles on first, last, interrupt-exit and re-entry iterations.
// RL12 - Other repeat iterations through the window complete in a single cycle.
// RL13 - Without bit 15 or page bit 9 the access is an ordinary data-space access; at or above 8000h with a zero page register the code traps instead.
// RL14 - Byte reads use address bit 0 for the byte; word and double reads return whole consecutive words.
module program_space_data_window (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	input wire logic clockEnable,
	// cpu request
	input wire logic reqValid,
	input wire window_pkg::req_s req,
	// program flash read port (combinational read, 24-bit words)
	output logic [22:0] flashAddr,
	output logic flashRead,
	input wire logic [23:0] flashWord,
	input wire logic [23:0] flashWordNext,
	// data-space pass through
	output logic dataSpaceRead,
	output logic dataSpaceWrite,
	output logic [15:0] dataSpaceAddr,
	input wire logic [15:0] dataSpaceRdata,
	// answer
	output logic rspValid,
	output window_pkg::rsp_s rsp
);
	logic redirect, upperHalf;
	logic [22:0] progAddr;
	logic [22:0] flashAddr_ff, nxt_flashAddr;
	logic flashRead_ff, nxt_flashRead;
	logic dataSpaceRead_ff, nxt_dataSpaceRead, dataSpaceWrite_ff, nxt_dataSpaceWrite;
	logic [15:0] dataSpaceAddr_ff, nxt_dataSpaceAddr;
	logic rspValid_ff, nxt_rspValid;
	window_pkg::rsp_s rsp_ff, nxt_rsp;

	window_addr_map window_addr_map_i (
		.effective_addr(req.effective_addr),
		.data_read_page_register(req.readPage),
		.redirect(redirect),
		.upperHalf(upperHalf),
		.progAddr(progAddr)
	);

	function automatic logic [15:0] halfOf(input logic [23:0] w, input logic up);
		halfOf = up ? {8'h00, w[23:16]} : w[15:0]; // RL4 RL8
	endfunction : halfOf

	function automatic logic [15:0] pickByte(input logic [15:0] w, input logic sel);
		pickByte = sel ? {8'h00, w[15:8]} : {8'h00, w[7:0]}; // RL14
	endfunction : pickByte

	logic inWindow, trap, winRead;
	logic [15:0] lo, hi;
	logic [1:0] extra;
	always_comb begin
		inWindow = req.effective_addr >= `WIN_BASE;
		trap = inWindow & ((req.isRead & (req.readPage == `WIN_PAGE_ZERO)) |
			(req.isWrite & (req.writePage == `WIN_PAGE_ZERO))); // RL9
		winRead = redirect & req.isRead; // RL1 RL2
		lo = halfOf(flashWord, upperHalf);
		hi = halfOf(flashWordNext, upperHalf);
		if (!winRead) begin
			extra = 2'h0;
		end else if (!req.inRepeat) begin
			extra = req.isMov ? `WIN_EXTRA_MOV : `WIN_EXTRA_OTHER; // RL10
		end else if (req.repFirst | req.repLast | req.repIntExit | req.repIntEntry) begin
			extra = `WIN_EXTRA_OTHER; // RL11
		end else begin
			extra = 2'h0; // RL12
		end
		nxt_flashAddr = flashAddr_ff;
		nxt_flashRead = 1'b0;
		nxt_dataSpaceRead = 1'b0;
		nxt_dataSpaceWrite = 1'b0;
		nxt_dataSpaceAddr = dataSpaceAddr_ff;
		nxt_rspValid = 1'b0;
		nxt_rsp = rsp_ff;
		if (reqValid) begin
			nxt_rspValid = 1'b1;
			nxt_rsp.trap = trap;
			nxt_rsp.extraCycles = extra;
			nxt_rsp.redirected = winRead & !trap;
			nxt_rsp.data = 16'h0000;
			nxt_rsp.dataHi = 16'h0000;
			if (trap) begin
				nxt_rsp.extraCycles = 2'h0;
			end else if (winRead) begin
				nxt_flashRead = 1'b1;
				nxt_flashAddr = progAddr; // RL3
				nxt_rsp.data = (req.size == window_pkg::SZ_BYTE) ? pickByte(lo, req.effective_addr[0]) : lo; // RL14
				nxt_rsp.dataHi = (req.size == window_pkg::SZ_DWORD) ? hi : 16'h0000; // RL14
			end else if (redirect & req.isWrite) begin
				nxt_rsp.data = 16'h0000; // RL8
			end else begin
				nxt_dataSpaceRead = req.isRead; // RL13
				nxt_dataSpaceWrite = req.isWrite;
				nxt_dataSpaceAddr = req.effective_addr;
				nxt_rsp.data = dataSpaceRdata;
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			flashAddr_ff <= 23'h000000;
			flashRead_ff <= 1'b0;
			dataSpaceRead_ff <= 1'b0;
			dataSpaceWrite_ff <= 1'b0;
			dataSpaceAddr_ff <= 16'h0000;
			rspValid_ff <= 1'b0;
			rsp_ff <= '0;
		end else if (clockEnable) begin
			flashAddr_ff <= nxt_flashAddr;
			flashRead_ff <= nxt_flashRead;
			dataSpaceRead_ff <= nxt_dataSpaceRead;
			dataSpaceWrite_ff <= nxt_dataSpaceWrite;
			dataSpaceAddr_ff <= nxt_dataSpaceAddr;
			rspValid_ff <= nxt_rspValid;
			rsp_ff <= nxt_rsp;
		end
	end

	assign flashAddr = flashAddr_ff;
	assign flashRead = flashRead_ff;
	assign dataSpaceRead = dataSpaceRead_ff;
	assign dataSpaceWrite = dataSpaceWrite_ff;
	assign dataSpaceAddr = dataSpaceAddr_ff;
	assign rspValid = rspValid_ff;
	assign rsp = rsp_ff;

	// checks on the registered answer
	property p_redirect;
		@(posedge clock) disable iff (rst)
		clockEnable && reqValid && req.isRead && !req.isWrite && req.effective_addr[15] && req.readPage[9]
			|=> flashRead && flashAddr == $past(progAddr);
	endproperty
	a_redirect: assert property (p_redirect) else $error("window read not redirected"); // RL2
	property p_addr;
		@(posedge clock) disable iff (rst)
		flashRead && $past(clockEnable)
			|-> flashAddr[14:0] == $past(req.effective_addr[14:0]) && flashAddr[22:15] == $past(req.readPage[7:0]);
	endproperty
	a_addr: assert property (p_addr) else $error("program address malformed"); // RL3
	property p_plain;
		@(posedge clock) disable iff (rst)
		clockEnable && reqValid && !req.effective_addr[15] |=> !flashRead && rspValid && !rsp.redirected;
	endproperty
	a_plain: assert property (p_plain) else $error("low address redirected"); // RL13
	property p_trap;
		@(posedge clock) disable iff (rst)
		clockEnable && reqValid && req.isRead && req.effective_addr[15] && req.readPage == 10'h000 |=> rsp.trap;
	endproperty
	a_trap: assert property (p_trap) else $error("page zero trap missing"); // RL9
	property p_mov;
		@(posedge clock) disable iff (rst)
		clockEnable && reqValid && req.isRead && !req.isWrite && req.readPage[9] && req.effective_addr[15] && !req.inRepeat
			&& req.isMov |=> rsp.extraCycles == 2'h1;
	endproperty
	a_mov: assert property (p_mov) else $error("move extra cycle wrong"); // RL10
	property p_repmid;
		@(posedge clock) disable iff (rst)
		clockEnable && reqValid && req.inRepeat && !req.repFirst && !req.repLast && !req.repIntExit && !req.repIntEntry
			|=> rsp.extraCycles == 2'h0;
	endproperty
	a_repmid: assert property (p_repmid) else $error("repeat middle not single cycle"); // RL12
	property p_repedge;
		@(posedge clock) disable iff (rst)
		clockEnable && reqValid && req.isRead && !req.isWrite && req.readPage[9] && req.effective_addr[15] && req.inRepeat
			&& req.repFirst |=> rsp.extraCycles == 2'h2;
	endproperty
	a_repedge: assert property (p_repedge) else $error("repeat first iteration cost wrong"); // RL11
	property p_readonly;
		@(posedge clock) disable iff (rst)
		clockEnable && reqValid && req.isWrite && req.effective_addr[15] && req.readPage[9] |=> !dataSpaceWrite;
	endproperty
	a_readonly: assert property (p_readonly) else $error("write through window"); // RL8
	property p_trapquiet;
		@(posedge clock) disable iff (rst)
		clockEnable && reqValid && req.isWrite && req.effective_addr[15] && req.writePage == `WIN_PAGE_ZERO
			|=> rsp.trap && !dataSpaceWrite && !flashRead && rsp.extraCycles == 2'h0;
	endproperty
	a_trapquiet: assert property (p_trapquiet) else $error("write page zero trap wrong"); // RL9
	property p_lower;
		@(posedge clock) disable iff (rst)
		clockEnable && reqValid && req.isRead && !req.isWrite && req.effective_addr[15] && req.readPage[9]
			&& !req.readPage[8] && req.size == window_pkg::SZ_WORD |=> rsp.data == $past(flashWord[15:0]);
	endproperty
	a_lower: assert property (p_lower) else $error("lower word not returned"); // RL4
	property p_upper;
		@(posedge clock) disable iff (rst)
		clockEnable && reqValid && req.isRead && !req.isWrite && req.effective_addr[15] && req.readPage[9]
			&& req.readPage[8] && req.size == window_pkg::SZ_WORD |=> rsp.data == {8'h00, $past(flashWord[23:16])};
	endproperty
	a_upper: assert property (p_upper) else $error("upper word not returned"); // RL6
	property p_dword;
		@(posedge clock) disable iff (rst)
		clockEnable && reqValid && req.isRead && !req.isWrite && req.effective_addr[15] && req.readPage[9]
			&& req.size == window_pkg::SZ_DWORD
			|=> rsp.dataHi == ($past(req.readPage[8]) ? {8'h00, $past(flashWordNext[23:16])} : $past(flashWordNext[15:0]));
	endproperty
	a_dword: assert property (p_dword) else $error("second word of double read wrong"); // RL14
	property p_pass;
		@(posedge clock) disable iff (rst)
		clockEnable && reqValid && req.isWrite && !req.isRead && !req.effective_addr[15]
			|=> dataSpaceWrite && dataSpaceAddr == $past(req.effective_addr);
	endproperty
	a_pass: assert property (p_pass) else $error("ordinary write not passed through"); // RL13
	c_win: cover property (@(posedge clock) flashRead && !rsp.trap);
	c_trap: cover property (@(posedge clock) rsp.trap);
	c_plain: cover property (@(posedge clock) dataSpaceRead);
	c_write: cover property (@(posedge clock) dataSpaceWrite);
	c_dword: cover property (@(posedge clock) rspValid && rsp.redirected && rsp.dataHi != 16'h0000);
endmodule : program_space_data_window

// [flash_partner.sv]
`timescale 1ns/1ps
module flash_partner (
	// request seen by the flash and data space
	input wire window_pkg::req_s req,
	// combinational read data
	output logic [23:0] flashWord,
	output logic [23:0] flashWordNext,
	output logic [15:0] dataSpaceRdata
);
	logic [22:0] addr;
	logic [22:0] addrNext;
	// address-dependent pattern so every word differs
	function automatic logic [23:0] pattern(input logic [22:0] a);
		return {a[22:15] ^ a[7:0], a[15:0] ^ 16'h5a3c};
	endfunction : pattern
	assign addr = {req.readPage[7:0], req.effective_addr[14:0]};
	assign addrNext = addr + 23'h000001;
	assign flashWord = pattern(addr);
	assign flashWordNext = pattern(addrNext);
	assign dataSpaceRdata = ~req.effective_addr ^ 16'h0f0f;
endmodule : flash_partner

// [tb_program_space_data_window.sv]
`timescale 1ns/1ps
module tb_program_space_data_window;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic clockEnable = 1'b1;
	logic ceLast = 1'b0;
	logic reqValid = 1'b0;
	window_pkg::req_s req = '0;
	window_pkg::req_s r;
	window_pkg::rsp_s rsp;
	logic [23:0] flashWord, flashWordNext;
	logic [15:0] dataSpaceRdata, dataSpaceAddr, half, halfHi, expData, expHi;
	logic [22:0] flashAddr, expAddr;
	logic flashRead, dataSpaceRead, dataSpaceWrite, rspValid, win, mapped, trap, dsRead, dsWrite;
	logic [1:0] expExtra;
	logic [77:0] got;
	logic [77:0] notes[$];
	logic [9:0] pages[6] = '{10'h000, 10'h200, 10'h2ff, 10'h300, 10'h3ff, 10'h202};
	int seed = 51704;
	int mismatches = 0;
	int checks_done = 0;
	always #2.5 clock = ~clock;
	// a frozen edge leaves the last answer standing, so only answers launched by an enabled edge are checked
	always @(posedge clock) ceLast <= clockEnable;
	program_space_data_window program_space_data_window_i (.clock(clock), .rst(rst), .clockEnable(clockEnable),
		.reqValid(reqValid), .req(req), .flashAddr(flashAddr), .flashRead(flashRead), .flashWord(flashWord),
		.flashWordNext(flashWordNext), .dataSpaceRead(dataSpaceRead), .dataSpaceWrite(dataSpaceWrite),
		.dataSpaceAddr(dataSpaceAddr), .dataSpaceRdata(dataSpaceRdata), .rspValid(rspValid), .rsp(rsp));
	flash_partner flash_partner_i (.req(req), .flashWord(flashWord), .flashWordNext(flashWordNext),
		.dataSpaceRdata(dataSpaceRdata));
	task check(input logic [77:0] seen, input logic [77:0] expected);
		checks_done++;
		if (seen !== expected) begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, expected);
		end
	endtask : check
	task stop_test;
		$display("mismatches %0d checks_done %0d", mismatches, checks_done);
		if (mismatches == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : stop_test
	// each response is matched against the oldest noted request
	always @(negedge clock) begin
		if (rspValid === 1'b1 && ceLast === 1'b1) begin
			got = {flashRead ? flashAddr : 23'h0, rsp.data, rsp.dataHi, rsp.trap, rsp.extraCycles, rsp.redirected,
				flashRead, dataSpaceRead, dataSpaceWrite, (dataSpaceRead | dataSpaceWrite) ? dataSpaceAddr : 16'h0};
			if (notes.size() == 0)
				check(78'h1, 78'h0);
			else
				check(got, notes.pop_front());
		end
	end
	initial begin
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		for (int i = 0; i < 400; i++) begin
			@(posedge clock);
			r = '0;
			r.effective_addr = 16'($random(seed));
			r.readPage = (i % 7 == 6) ? 10'($random(seed)) : pages[i % 6];
			r.isWrite = ($random(seed) & 3) == 0;
			r.isRead = !r.isWrite;
			r.writePage = (i % 5 == 4) ? 10'h000 : 10'h001;
			r.size = window_pkg::size_e'(2'($unsigned($random(seed)) % 3));
			// ordinary accesses are kept to whole words
			if (!(r.effective_addr[15] && r.readPage[9]))
				r.size = window_pkg::SZ_WORD;
			{r.isMov, r.inRepeat, r.repFirst, r.repLast, r.repIntExit, r.repIntEntry} = 6'($random(seed));
			req <= r;
			reqValid <= ($random(seed) & 3) != 0;
			clockEnable <= (i % 9) != 8;
			@(negedge clock);
			if (reqValid && clockEnable) begin
				mapped = req.effective_addr[15] & req.readPage[9];
				trap = req.effective_addr[15] & ((req.isRead & (req.readPage == 10'h000)) |
					(req.isWrite & (req.writePage == 10'h000)));
				win = mapped & req.isRead & !trap;
				dsRead = !mapped & !trap & req.isRead;
				dsWrite = !mapped & !trap & req.isWrite;
				half = req.readPage[8] ? {8'h00, flashWord[23:16]} : flashWord[15:0];
				halfHi = req.readPage[8] ? {8'h00, flashWordNext[23:16]} : flashWordNext[15:0];
				if (req.size == window_pkg::SZ_BYTE)
					half = {8'h00, req.effective_addr[0] ? half[15:8] : half[7:0]};
				expHi = (win && req.size == window_pkg::SZ_DWORD) ? halfHi : 16'h0000;
				expExtra = !win ? 2'h0 : !req.inRepeat ? (req.isMov ? 2'h1 : 2'h2) :
					(req.repFirst | req.repLast | req.repIntExit | req.repIntEntry) ? 2'h2 : 2'h0;
				expData = win ? half : (trap | mapped) ? 16'h0000 : dataSpaceRdata;
				expAddr = win ? {req.readPage[7:0], req.effective_addr[14:0]} : 23'h0;
				notes.push_back({expAddr, expData, expHi, trap, expExtra, win, win, dsRead, dsWrite,
					(dsRead | dsWrite) ? req.effective_addr : 16'h0});
			end
		end
		// the last request is taken at this edge; drop valid so it is not taken again
		@(posedge clock);
		reqValid <= 1'b0;
		repeat (4) @(posedge clock);
		stop_test();
	end
	initial begin
		#5000;
		mismatches++;
		stop_test();
	end
endmodule : tb_program_space_data_window
